// *** core/flash_program_protect_ctrl.sv ***
// flash program/erase control bits and block protection behind an AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "flash_ctrl_regs.svh"
module flash_program_protect_ctrl (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_HSEL,
  input wire logic [11:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_TEST_HIGH_VOLTAGE,
  output logic O_PROGRAM_SELECT,
  output logic O_ERASE_SELECT,
  output logic O_HIGH_VOLTAGE_ENABLE,
  output logic O_READ_READY,
  output logic O_MONITOR_ENTRY_OK
);
  import flash_ctrl_pkg::*;
  localparam int REC_CYCLES = `RECOVERY_CYCLES;
  localparam int REC_LAST = REC_CYCLES - 1;
  // the recovery counter is eight bits wide and must count at least one cycle
  if (REC_CYCLES < 1 || REC_CYCLES > 256)
  begin
    $error("recovery count must be between 1 and 256 cycles");
  end

  // address phase capture
  logic wr_pend_q, wr_pend_d;
  logic [11:0] addr_q, addr_d;
  logic vtst_s1_q, vtst_s2_q, vtst_s3_q, vtst_q, vtst_d;
  logic [3:0] ctrl_q, ctrl_d;
  logic [7:0] protect_q, protect_d;
  logic [15:0] target_q, target_d;
  logic refused_q, refused_d;
  logic [31:0] rdata_q, rdata_d;
  hv_state_e st_q, st_d;
  logic [7:0] rec_cnt_q, rec_cnt_d;
  logic take;
  logic wr_ctrl, wr_prot, wr_tgt;
  prot_check_if chk ();

  assign take = I_HSEL && I_HREADY && I_HTRANS[1];
  assign wr_ctrl = wr_pend_q && (addr_q == `CTRL_OFFSET);
  assign wr_prot = wr_pend_q && (addr_q == `PROTECT_OFFSET);
  assign wr_tgt = wr_pend_q && (addr_q == `TARGET_OFFSET);

  // low write-data fields, named so the assertions can look back at them
  logic [7:0] wdata_byte;
  logic [1:0] wdata_sel;
  assign wdata_byte = I_HWDATA[7:0];
  assign wdata_sel = I_HWDATA[1:0];

  // the checker sees the pending target; mass is the mass bit being written or held
  assign chk.protect = protect_q;
  assign chk.target = wr_tgt ? I_HWDATA[15:0] : target_q;
  assign chk.mass = wr_ctrl ? I_HWDATA[`CTRL_MASS_BIT] : ctrl_q[`CTRL_MASS_BIT];
  flash_prot_check u_check (
    .chk(chk.check)
  );

  // test voltage pin: three stages, a change counts once the last two agree
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      vtst_s1_q <= 1'b0;
      vtst_s2_q <= 1'b0;
      vtst_s3_q <= 1'b0;
    end
    else
    begin
      vtst_s1_q <= I_TEST_HIGH_VOLTAGE;
      vtst_s2_q <= vtst_s1_q;
      vtst_s3_q <= vtst_s2_q;
    end
  end

  // next-state logic for bus capture, control bits, protect register and hv sequencer
  always_comb
  begin
    wr_pend_d = take && I_HWRITE;
    addr_d = take ? I_HADDR : addr_q;
    vtst_d = (vtst_s2_q == vtst_s3_q) ? vtst_s3_q : vtst_q;
    ctrl_d = ctrl_q;
    protect_d = protect_q;
    target_d = wr_tgt ? I_HWDATA[15:0] : target_q;
    refused_d = refused_q;
    st_d = st_q;
    rec_cnt_d = rec_cnt_q;
    if (wr_ctrl)
    begin
      ctrl_d[2:0] = I_HWDATA[2:0];
      // decision taken at the write attempt itself, so a later protect change cannot sneak hv on
      if (I_HWDATA[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT] && !ctrl_q[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT])
      begin
        ctrl_d[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT] = !chk.is_protected;
        refused_d = chk.is_protected;
      end
      else
        ctrl_d[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT] = I_HWDATA[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT];
    end
    // protect register alters only with test voltage present
    if (wr_prot && vtst_q)
      protect_d = I_HWDATA[7:0];
    case (st_q)
      ST_READ:
      begin
        if (ctrl_d[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT])
          st_d = ST_HV;
      end
      ST_HV:
      begin
        if (!ctrl_d[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT])
        begin
          st_d = ST_RECOVER;
          rec_cnt_d = 8'(REC_CYCLES - 1);
        end
      end
      ST_RECOVER:
      begin
        // array stays busy for the recovery time after hv drops
        if (ctrl_d[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT])
          st_d = ST_HV;
        else if (rec_cnt_q == 8'h00)
          st_d = ST_READ;
        else
          rec_cnt_d = rec_cnt_q - 8'h01;
      end
      default:
        st_d = ST_READ;
    endcase
    case (addr_d)
      `CTRL_OFFSET: rdata_d = {28'h0000000, ctrl_d};
      `PROTECT_OFFSET: rdata_d = {24'h000000, protect_d};
      `STATUS_OFFSET: rdata_d = {28'h0000000, vtst_q, refused_q, st_q};
      `TARGET_OFFSET: rdata_d = {16'h0000, target_d};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // register stage for everything above
  always_ff @(posedge I_CLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= 12'h000;
      vtst_q <= 1'b0;
      ctrl_q <= 4'h0;
      protect_q <= `PROTECT_RESET;
      target_q <= 16'h0000;
      refused_q <= 1'b0;
      rdata_q <= 32'h00000000;
      st_q <= ST_READ;
      rec_cnt_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      addr_q <= addr_d;
      vtst_q <= vtst_d;
      ctrl_q <= ctrl_d;
      protect_q <= protect_d;
      target_q <= target_d;
      refused_q <= refused_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      rec_cnt_q <= rec_cnt_d;
    end
  end

  // zero wait state slave, always okay
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
  assign O_HRDATA = rdata_q;
  assign O_PROGRAM_SELECT = ctrl_q[`CTRL_PGM_BIT];
  assign O_ERASE_SELECT = ctrl_q[`CTRL_ERASE_BIT];
  assign O_HIGH_VOLTAGE_ENABLE = ctrl_q[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT];
  assign O_READ_READY = (st_q == ST_READ);
  assign O_MONITOR_ENTRY_OK = vtst_q;

  property p_hv_refused;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (wr_ctrl && I_HWDATA[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT] && !ctrl_q[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT] && chk.is_protected) |=> !O_HIGH_VOLTAGE_ENABLE;
  endproperty
  a_hv_refused: assert property (p_hv_refused) else $error("hv set on protected target");

  property p_hv_granted;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (wr_ctrl && I_HWDATA[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT] && !chk.is_protected) |=> O_HIGH_VOLTAGE_ENABLE;
  endproperty
  a_hv_granted: assert property (p_hv_granted) else $error("hv refused on open target");

  property p_recovery;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    $fell(O_HIGH_VOLTAGE_ENABLE) |-> !O_READ_READY ##REC_CYCLES O_READ_READY || O_HIGH_VOLTAGE_ENABLE;
  endproperty
  a_recovery: assert property (p_recovery) else $error("read recovery time wrong");

  property p_protect_locked;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    !vtst_q |=> $stable(protect_q);
  endproperty
  a_protect_locked: assert property (p_protect_locked) else $error("protect changed without test voltage");

  property p_mass_blocked;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (protect_q != `PROTECT_OPEN && wr_ctrl && I_HWDATA[`CTRL_MASS_BIT] && I_HWDATA[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT]
      && !ctrl_q[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT]) |=> !O_HIGH_VOLTAGE_ENABLE && refused_q;
  endproperty
  a_mass_blocked: assert property (p_mass_blocked) else $error("mass erase with protection");

  property p_all_open;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (protect_q == `PROTECT_OPEN) |-> !chk.is_protected;
  endproperty
  a_all_open: assert property (p_all_open) else $error("all ones still protects");

  property p_all_closed;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (protect_q == 8'h00) |-> chk.is_protected;
  endproperty
  a_all_closed: assert property (p_all_closed) else $error("all zeros leaves memory open");

  property p_top_protected;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (protect_q != `PROTECT_OPEN && chk.target == `TOP_ADDR) |-> chk.is_protected;
  endproperty
  a_top_protected: assert property (p_top_protected) else $error("top address not protected");

  // hv may only move on a control write; nothing else in the block touches it
  property p_hv_write_only;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    !wr_ctrl |=> $stable(O_HIGH_VOLTAGE_ENABLE);
  endproperty
  a_hv_write_only: assert property (p_hv_write_only) else $error("hv moved without a control write");

  // a rising hv must trace back to an open target at the write
  property p_hv_rise_open;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    $rose(O_HIGH_VOLTAGE_ENABLE) |-> !$past(chk.is_protected);
  endproperty
  a_hv_rise_open: assert property (p_hv_rise_open) else $error("hv rose on a protected target");

  // mass erase hv only while the protect register is all ones
  property p_mass_open;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    ($rose(O_HIGH_VOLTAGE_ENABLE) && ctrl_q[`CTRL_MASS_BIT]) |-> ($past(protect_q) == `PROTECT_OPEN);
  endproperty
  a_mass_open: assert property (p_mass_open) else $error("mass erase hv while a block is locked");

  // the refused flag records the decision of the latest hv attempt
  property p_refused_flag;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (wr_ctrl && I_HWDATA[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT] && !ctrl_q[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT]) |=> (refused_q == $past(chk.is_protected));
  endproperty
  a_refused_flag: assert property (p_refused_flag) else $error("refused flag does not match decision");

  // selects are taken even when hv is refused, so software can read them back
  property p_select_written;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    wr_ctrl |=> ({O_ERASE_SELECT, O_PROGRAM_SELECT} == $past(wdata_sel));
  endproperty
  a_select_written: assert property (p_select_written) else $error("select bits not taken from write");

  // clearing hv is never refused; it starts the read recovery
  property p_hv_cleared;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (wr_ctrl && !I_HWDATA[`CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT]) |=> !O_HIGH_VOLTAGE_ENABLE;
  endproperty
  a_hv_cleared: assert property (p_hv_cleared) else $error("hv clear not applied");

  // array is still unreadable at the last cycle of the recovery span, not only at its start
  property p_recovery_low;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    $fell(O_HIGH_VOLTAGE_ENABLE) |-> ##REC_LAST !O_READ_READY;
  endproperty
  a_recovery_low: assert property (p_recovery_low) else $error("array readable before recovery ends");

  // hv and read access never overlap
  property p_hv_no_read;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    O_HIGH_VOLTAGE_ENABLE |-> !O_READ_READY;
  endproperty
  a_hv_no_read: assert property (p_hv_no_read) else $error("array readable while hv set");

  // with test voltage present the written byte lands exactly
  property p_protect_written;
    @(posedge I_CLK) disable iff (!I_ARST_N)
    (wr_prot && vtst_q) |=> (protect_q == $past(wdata_byte));
  endproperty
  a_protect_written: assert property (p_protect_written) else $error("protect write with test voltage lost");
endmodule

// *** core/flash_ctrl_regs.svh ***
// register offsets, field positions, reset values and timing counts for the flash controller
`ifndef FLASH_CTRL_REGS_SVH
`define FLASH_CTRL_REGS_SVH
`define CTRL_OFFSET 12'h000
`define PROTECT_OFFSET 12'h004
`define STATUS_OFFSET 12'h008
`define TARGET_OFFSET 12'h00c
`define CTRL_PGM_BIT 0
`define CTRL_ERASE_BIT 1
`define CTRL_MASS_BIT 2
`define CTRL_HIGH_VOLTAGE_ENABLE_BIT_BIT 3
`define PROTECT_RESET 8'hff
`define PROTECT_OPEN 8'hff
`define TOP_ADDR 16'hffff
`define FLASH_BASE 16'hf000
`define CLK_MHZ 10
`define RECOVERY_TIME_US 1
`define RECOVERY_CYCLES (`RECOVERY_TIME_US * `CLK_MHZ)
`endif

// *** core/flash_ctrl_pkg.sv ***
// types shared by the flash controller files
package flash_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_READ = 2'b00,
    ST_HV = 2'b01,
    ST_RECOVER = 2'b10
  } hv_state_e;
endpackage

// *** core/prot_check_if.sv ***
// carrier between the controller and its protection checker
`timescale 1ns/1ps
interface prot_check_if;
  logic [7:0] protect;
  logic [15:0] target;
  logic mass;
  logic is_protected;
  modport ctrl (output protect, output target, output mass, input is_protected);
  modport check (input protect, input target, input mass, output is_protected);
endinterface

// *** core/flash_prot_check.sv ***
// protection decision for a target address or mass erase
`timescale 1ns/1ps
`include "flash_ctrl_regs.svh"
module flash_prot_check (
  prot_check_if.check chk
);
  import flash_ctrl_pkg::*;
  logic [15:0] start_addr;
  // protected range starts at base plus protect value times 64 bytes and runs to the top
  assign start_addr = `FLASH_BASE + {2'b00, chk.protect, 6'h00};
  // all zeros protects everything, all ones protects nothing
  always_comb
  begin
    if (chk.protect == `PROTECT_OPEN)
      chk.is_protected = 1'b0;
    else if (chk.mass)
      chk.is_protected = 1'b1;
    else if (chk.protect == 8'h00)
      chk.is_protected = 1'b1;
    else
      chk.is_protected = (chk.target >= start_addr) && (chk.target <= `TOP_ADDR);
  end
endmodule

// *** bench/sw_agent.sv ***
// software-side bus master model issuing flash program sequences
`timescale 1ns/1ps
`include "flash_ctrl_regs.svh"
module sw_agent (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [11:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata
);
  // idle bus at time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end

  // one single word transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= w ? wd : ~hwdata; // read phase data keeps toggling
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // target first, then select, read protection, then raise hv
  task automatic try_hv(input logic [15:0] t, input logic [31:0] c);
    logic [31:0] d;
    xfer(1'b1, `TARGET_OFFSET, {16'h0000, t}, d);
    xfer(1'b1, `CTRL_OFFSET, c & 32'h7, d);
    xfer(1'b0, `PROTECT_OFFSET, 32'h0, d);
    xfer(1'b1, `CTRL_OFFSET, c, d);
  endtask

  // byte time, select off, hold time, hv off; watchdog location never touched
  task automatic end_row;
    logic [31:0] d;
    repeat (300) @(posedge clk);
    xfer(1'b1, `CTRL_OFFSET, 32'h8, d);
    repeat (50) @(posedge clk);
    xfer(1'b1, `CTRL_OFFSET, 32'h0, d);
  endtask
endmodule

// *** bench/tb_flash_program_protect_ctrl.sv ***
// self-checking bench for flash program control and block protection
`timescale 1ns/1ps
`include "flash_ctrl_regs.svh"
module tb_flash_program_protect_ctrl;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tv = 1'b0;
  logic hsel, hwrite, hready, hresp, program_select_bit, ers, hv, rdy, mon;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, d, c, rnd;
  logic [15:0] t;
  logic [7:0] p;
  logic e;
  int bad_count = 0;
  int compares = 0;

  always #50 clk = ~clk;

  sw_agent agent (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));

  flash_program_protect_ctrl DUT (.I_CLK(clk), .I_ARST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'b010), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_TEST_HIGH_VOLTAGE(tv),
    .O_PROGRAM_SELECT(program_select_bit), .O_ERASE_SELECT(ers), .O_HIGH_VOLTAGE_ENABLE(hv),
    .O_READ_READY(rdy), .O_MONITOR_ENTRY_OK(mon));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // protected when start of range reached, mass when any block locked, every target when all zeros
  function automatic logic exp_prot(input logic [7:0] pv, input logic [15:0] tv_a, input logic m);
    if (pv == 8'hff)
      return 1'b0;
    if (pv == 8'h00)
      return 1'b1;
    return m | ({1'b0, tv_a} >= (17'h0f000 + {3'b000, pv, 6'h00}));
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // watchdog: the whole run needs well under a millisecond
  initial
  begin
    #2000000;
    bad_count++;
    close_out();
  end

  // main sequence: lock, unlock and program attempts per protect value
  initial
  begin
    rnd = 32'hc7b25f79;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    agent.xfer(1'b0, `PROTECT_OFFSET, 32'h0, d);
    check(d, 32'hff);
    #1 check({31'h0, rdy}, 32'h1);
    agent.xfer(1'b1, `PROTECT_OFFSET, 32'h0, d);
    check({31'h0, hresp}, 32'h0);
    agent.xfer(1'b0, `PROTECT_OFFSET, 32'h0, d);
    check(d, 32'hff);
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      p = (k == 0) ? {2'b00, rnd[5:0]} : ((k == 1) ? 8'h00 : 8'hff);
      tv <= 1'b1;
      repeat (4) @(posedge clk);
      #1 check({31'h0, mon}, 32'h1);
      agent.xfer(1'b1, `PROTECT_OFFSET, {24'h0, p}, d);
      agent.xfer(1'b0, `PROTECT_OFFSET, 32'h0, d);
      check(d, {24'h0, p});
      tv <= 1'b0;
      repeat (4) @(posedge clk);
      #1 check({31'h0, mon}, 32'h0);
      agent.xfer(1'b1, `PROTECT_OFFSET, {24'h0, ~p}, d);
      agent.xfer(1'b0, `PROTECT_OFFSET, 32'h0, d);
      check(d, {24'h0, p});
      for (int j = 0; j < 4; j++)
      begin
        rnd = lfsr(rnd);
        t = 16'hf000 | {4'h0, rnd[11:0]};
        if (j < 2)
          t = 16'hf000 + {2'b00, p, 6'h00} - {15'h0, j[0]};
        c = (j == 3) ? 32'he : 32'h9;
        e = exp_prot(p, t, j == 3);
        agent.try_hv(t, c);
        #1 check({31'h0, hv}, {31'h0, ~e});
        check({30'h0, ers, program_select_bit}, {30'h0, c[1:0]});
        agent.xfer(1'b0, `STATUS_OFFSET, 32'h0, d);
        check({28'h0, d[3:0]}, {28'h0, 1'b0, e, 1'b0, ~e});
        if (!e)
        begin
          agent.end_row();
          #1 check({31'h0, rdy}, 32'h0);
          repeat (9) @(posedge clk);
          #1 check({31'h0, rdy}, 32'h0);
          @(posedge clk);
          #1 check({31'h0, rdy}, 32'h1);
        end
        else
          agent.xfer(1'b1, `CTRL_OFFSET, 32'h0, d);
      end
    end
    close_out();
  end
endmodule
